// ---- hwd_defines.svh ----
// Purpose: Constants for the hardware watchdog with software reset.
// Assumes: Included by its bare name from every design file except the package.
// Notes: Widths that may differ are module parameters, not defines.
`ifndef HWD_DEFINES_SVH
`define HWD_DEFINES_SVH
// Sequence port byte values.
`define HWD_FEED_FIRST 8'h1E
`define HWD_FEED_SECOND 8'hE1
`define HWD_SRST_FIRST 8'h5A
`define HWD_SRST_SECOND 8'hA5
// Reset pulse lengths in system clocks, normal and double speed.
`define HWD_PULSE_NORMAL 7'd96
`define HWD_PULSE_DOUBLE 7'd48
// Default prescale setting and counter geometry.
`define HWD_PRESCALE_DEFAULT 7'h05
`define HWD_PRESCALE_BITS 7
`define HWD_COUNTER_BITS 14
`define HWD_PERIOD_LAST_CODE 3'h7
`endif

// ---- hwd_pkg.sv ----
// Purpose: Types shared by the watchdog modules.
// Assumes: Nothing beyond the defines header.
// Notes: Configuration travels as one packed struct.
package hwd_pkg;
    // Sequence decoder states: waiting, after feed byte one, after reset byte one.
    typedef enum logic [1:0] {HWD_WAIT, HWD_FEED_HALF, HWD_SRST_HALF} hwd_seq_t;
    // Static configuration bits steering the block.
    typedef struct packed {
        logic [6:0] timer_prescale_select;
        logic [2:0] period_select;
        logic idle_halt_select;
        logic reset_out_disable;
        logic double_speed_mode;
    } hwd_cfg_t;
    // Status bits shown to software.
    typedef struct packed {
        logic watchdog_overflow_flag;
        logic soft_reset_flag;
        logic watchdog_running_flag;
    } hwd_status_t;
endpackage

// ---- hwd_timebase.sv ----
// Purpose: Prescaler and time-out counter of the watchdog.
// Assumes: One clock; restart has priority over advance.
// Notes: The counter is sized for the longest period code.
`timescale 1ns/100ps
`include "hwd_defines.svh"
module hwd_timebase import hwd_pkg::*; #(
    parameter int PRESC_W = `HWD_PRESCALE_BITS,
    parameter int CNT_W = `HWD_COUNTER_BITS + `HWD_PRESCALE_BITS
) (
    // Clock, reset and clock enable.
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Control.
    input wire logic restart_i,
    input wire logic advance_i,
    input wire logic [PRESC_W-1:0] prescale_i,
    input wire logic [2:0] period_i,
    // Time-out strobe, one cycle.
    output logic timeout_o
);
    // Last count of the selected period: two to the power of code plus fourteen, less one.
    function automatic logic [CNT_W-1:0] period_last(input logic [2:0] code);
        period_last = {CNT_W{1'b1}} >> (CNT_W - `HWD_COUNTER_BITS - int'(code));
    endfunction

    logic [PRESC_W-1:0] pre_q; // Clocks within the current tick.
    logic [PRESC_W-1:0] pre_d; // Next prescaler value.
    logic [CNT_W-1:0] cnt_q; // Ticks within the current period.
    logic [CNT_W-1:0] cnt_d; // Next counter value.
    wire tick = advance_i && (pre_q == prescale_i); // A tick lasts prescale plus one clocks.
    wire last = cnt_q == period_last(period_i);

    assign timeout_o = tick && last;
    // A feed clears both stages, so every feed buys a whole period.
    assign pre_d = restart_i ? '0 : (!advance_i ? pre_q : (tick ? '0 : pre_q + 1'b1));
    assign cnt_d = restart_i ? '0 : (tick ? (last ? '0 : cnt_q + 1'b1) : cnt_q);

    // Both stages only move while the clock enable is high.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pre_q <= '0;
            cnt_q <= '0;
        end else if (clk_en_i) begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    restart_clears_a: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && restart_i |=> pre_q == '0 && cnt_q == '0)
        else $error("Restart did not clear the time base.");
    tick_spacing_a: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && advance_i && !restart_i && pre_q != prescale_i |=> cnt_q == $past(cnt_q))
        else $error("Counter moved between ticks.");
endmodule // hwd_timebase

// ---- hwd_watchdog.sv ----
// Purpose: Hardware watchdog with keyed feed and software reset sequences.
// Assumes: Sequence writes arrive as one-cycle strobes with their byte.
// Notes: The block's own reset pulse disables the watchdog but keeps the flags.
// Operation
// - Advance once per prescale plus one clocks.
// - Period code doubles time-out from 16K ticks.
// - Disabled after reset, stopped in power-down.
// - Time-out gives 96 clock pulse, 48 doubled.
// - Pulse drives reset pin unless disabled.
// - 21-bit counter behind 7-bit prescaler.
// - Bytes 1E then E1 start the watchdog.
// - Running flag reads one while running.
// - Wrong feed or enable resets at once.
// - Bytes 5A then A5 cause software reset.
// - Software reset works with watchdog stopped.
// - Software reset sets soft flag only.
// - Wrong sequence sets both flags, resets.
// - Software reset pulse matches watchdog pulse.
// - Flags stay set until software clears.
// - Idle halt bit pauses counting in idle.
`timescale 1ns/100ps
`include "hwd_defines.svh"
module hwd_watchdog import hwd_pkg::*; #(
    parameter int PRESC_W = `HWD_PRESCALE_BITS
) (
    // Clock, reset and clock enable.
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Sequence port write strobe and byte.
    input wire logic seq_wr_i,
    input wire logic [7:0] seq_data_i,
    // Configuration and device modes.
    input wire hwd_cfg_t cfg_i,
    input wire logic idle_mode_i,
    input wire logic power_down_i,
    // Flag clears from software.
    input wire logic overflow_clr_i,
    input wire logic soft_reset_clr_i,
    // Status and reset outputs.
    output hwd_status_t status_o,
    output logic reset_pulse_o,
    output logic reset_pin_o,
    output logic reset_pin_oe_o
);
    hwd_seq_t seq_q; // Sequence decoder state.
    hwd_seq_t seq_d; // Next decoder state.
    logic running_q; // Watchdog is counting.
    logic ovf_q; // Overflow flag.
    logic srst_q; // Software reset flag.
    logic pulse_q; // Internal reset pulse.
    logic pin_q; // Reset pin drive.
    logic [6:0] left_q; // Pulse cycles still to go after this one.
    logic timeout; // Time base overflow strobe.

    // Writes are ignored while the pulse runs; the processor is held in reset then.
    wire wr = seq_wr_i && !pulse_q;
    wire wait_feed = seq_q == HWD_WAIT && seq_data_i == `HWD_FEED_FIRST;
    wire wait_srst = seq_q == HWD_WAIT && seq_data_i == `HWD_SRST_FIRST;
    wire feed_ok = wr && seq_q == HWD_FEED_HALF && seq_data_i == `HWD_FEED_SECOND;
    wire srst_ok = wr && seq_q == HWD_SRST_HALF && seq_data_i == `HWD_SRST_SECOND;
    // Any byte that fits neither sequence is an error, in any state.
    wire bad_seq = wr && !wait_feed && !wait_srst && !feed_ok && !srst_ok;
    wire wd_fire = timeout && running_q && !pulse_q;
    wire start_pulse = wd_fire || bad_seq || srst_ok;
    // Counting pauses in power-down and, when asked, in idle.
    wire advance = running_q && !power_down_i && !(idle_mode_i && cfg_i.idle_halt_select);
    wire [6:0] pulse_len = cfg_i.double_speed_mode ? `HWD_PULSE_DOUBLE : `HWD_PULSE_NORMAL;

    // Decoder moves on a sequence write or a time-out; an error, completion or time-out returns it to waiting.
    always_comb begin
        seq_d = seq_q;
        if (wr) begin
            unique case (seq_q)
                HWD_WAIT: seq_d = wait_feed ? HWD_FEED_HALF : (wait_srst ? HWD_SRST_HALF : HWD_WAIT);
                HWD_FEED_HALF: seq_d = HWD_WAIT;
                HWD_SRST_HALF: seq_d = HWD_WAIT;
                default: seq_d = HWD_WAIT;
            endcase
        end
    end

    // The time base restarts on every valid feed and whenever the watchdog is off.
    hwd_timebase #(
        .PRESC_W(PRESC_W)
    ) u_timebase (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .restart_i(feed_ok || !running_q),
        .advance_i(advance),
        .prescale_i(cfg_i.timer_prescale_select),
        .period_i(cfg_i.period_select),
        .timeout_o(timeout)
    );

    // Sequence state and running flag.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            seq_q <= HWD_WAIT;
            running_q <= 1'b0;
        end else if (clk_en_i) begin
            seq_q <= start_pulse ? HWD_WAIT : seq_d;
            running_q <= start_pulse ? 1'b0 : (running_q || feed_ok);
        end
    end

    // Sticky flags: hardware sets, software clears, a set beats a clear in the same cycle.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ovf_q <= 1'b0;
            srst_q <= 1'b0;
        end else if (clk_en_i) begin
            ovf_q <= (wd_fire || bad_seq) || (ovf_q && !overflow_clr_i);
            srst_q <= (srst_ok || bad_seq) || (srst_q && !soft_reset_clr_i);
        end
    end

    // Reset pulse: the pin copy is decided once at the start so it ends with the pulse.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pulse_q <= 1'b0;
            pin_q <= 1'b0;
            left_q <= '0;
        end else if (clk_en_i) begin
            if (start_pulse && !pulse_q) begin
                pulse_q <= 1'b1;
                pin_q <= !cfg_i.reset_out_disable;
                left_q <= pulse_len - 7'h01;
            end else if (pulse_q) begin
                pulse_q <= left_q != 7'h00;
                pin_q <= pin_q && left_q != 7'h00;
                left_q <= left_q - 7'h01;
            end
        end
    end

    assign status_o = '{watchdog_overflow_flag: ovf_q, soft_reset_flag: srst_q, watchdog_running_flag: running_q};
    assign reset_pulse_o = pulse_q;
    assign reset_pin_o = pin_q;
    assign reset_pin_oe_o = pin_q;

    // Helper for the pulse length check: length chosen at start and cycles seen high.
    logic [6:0] len_seen_q;
    logic [6:0] len_want_q;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            len_seen_q <= '0;
            len_want_q <= '0;
        end else if (clk_en_i) begin
            len_seen_q <= pulse_q ? len_seen_q + 7'h01 : 7'h00;
            if (start_pulse && !pulse_q) begin
                len_want_q <= pulse_len;
            end
        end
    end

    pulse_length_a: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && pulse_q && left_q == 7'h00 |-> len_seen_q + 7'h01 == len_want_q)
        else $error("Reset pulse length wrong.");
    pulse_choice_a: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && start_pulse && !pulse_q |=> len_want_q == ($past(cfg_i.double_speed_mode) ? 7'd48 : 7'd96))
        else $error("Reset pulse length not taken from speed mode.");
    reset_pin_a: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && start_pulse && !pulse_q |=> reset_pin_o == !$past(cfg_i.reset_out_disable) && reset_pulse_o)
        else $error("Reset pin drive wrong at pulse start.");
    feed_start_a: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && wr && wait_feed ##1 clk_en_i && wr && seq_data_i == 8'hE1 |=> status_o.watchdog_running_flag)
        else $error("Feed sequence did not start the watchdog.");
    bad_byte_a: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && bad_seq |=> reset_pulse_o && status_o.watchdog_overflow_flag && status_o.soft_reset_flag)
        else $error("Wrong sequence did not reset with both flags.");
    soft_reset_a: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && srst_ok && !wd_fire |=> reset_pulse_o && status_o.soft_reset_flag
            && status_o.watchdog_overflow_flag == $past(ovf_q))
        else $error("Software reset flags wrong.");
    timeout_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && wd_fire |=> reset_pulse_o && status_o.watchdog_overflow_flag && !status_o.watchdog_running_flag)
        else $error("Time-out did not reset and flag.");
    flag_sticky_a: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && ovf_q && !overflow_clr_i |=> status_o.watchdog_overflow_flag)
        else $error("Overflow flag dropped without a clear.");
    idle_pause_a: assert property (@(posedge clock_i) disable iff (rst_i)
        running_q && idle_mode_i && cfg_i.idle_halt_select |-> !advance)
        else $error("Watchdog advanced in idle while halted.");
endmodule // hwd_watchdog

// ---- hwd_watchdog_bench.sv ----
// Purpose: Self-checking bench for the hardware watchdog with software reset.
// Assumes: Inputs change by non-blocking assignment on the rising clock edge.
// Notes: Prescale 0 or 1 and period 0 keep time-outs near 16K or 32K clocks, so the run stays short.
`timescale 1ns/100ps
`include "hwd_defines.svh"
module hwd_watchdog_bench import hwd_pkg::*;;
    // Stimulus and observed signals.
    logic clock_i, rst_i, seq_wr, idle, pdn, oclr, sclr;
    logic ce; // Clock enable driven into the design.
    logic [7:0] seq_data;
    hwd_cfg_t cfg;
    hwd_status_t status;
    logic pulse, pin, pin_oe;
    int miscompares = 0; // Mismatches seen so far.
    int num_checks = 0; // Comparisons made so far.
    int cyc = 0; // Cycle count for the hang guard.

    // Clock enable is driven so that one scenario can check the freeze.
    hwd_watchdog u_dut (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(ce), .seq_wr_i(seq_wr),
        .seq_data_i(seq_data), .cfg_i(cfg), .idle_mode_i(idle), .power_down_i(pdn),
        .overflow_clr_i(oclr), .soft_reset_clr_i(sclr), .status_o(status), .reset_pulse_o(pulse),
        .reset_pin_o(pin), .reset_pin_oe_o(pin_oe));

    // A 40 ns clock period.
    initial begin
        clock_i = 1'h0;
        forever #20 clock_i = ~clock_i;
    end

    // Prints the verdict and ends the run from one place.
    task automatic tally_and_finish();
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Compares one observed value with its expectation.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // Writes one or two bytes back to back; the strobe stays high between them.
    // No other write ever falls between the two bytes of a sequence.
    task automatic send(input logic [7:0] a, input logic [7:0] b, input bit two);
        @(posedge clock_i);
        seq_wr <= 1'h1;
        seq_data <= a;
        if (two) begin
            @(posedge clock_i);
            seq_data <= b;
        end
        @(posedge clock_i);
        seq_wr <= 1'h0;
    endtask

    // Checks the pin copy at the start of a pulse, then measures the pulse length.
    task automatic pulse_chk(input int exp_len, input logic exp_pin);
        int n = 0;
        // The pulse rises at the edge on which the sender returns, so look just after it.
        #1;
        chk("reset_pin", pin, exp_pin);
        chk("reset_pin_oe", pin_oe, exp_pin);
        while (pulse === 1'h1 && n < 200) begin
            n++;
            @(posedge clock_i);
            #1;
        end
        chk("pulse_len", n, exp_len);
    endtask

    // Clears both flags and confirms that they were held until then.
    task automatic clr(input logic ovf_exp, input logic soft_exp);
        chk("ovf_held", status.watchdog_overflow_flag, ovf_exp);
        chk("soft_held", status.soft_reset_flag, soft_exp);
        @(posedge clock_i);
        oclr <= 1'h1;
        sclr <= 1'h1;
        @(posedge clock_i);
        oclr <= 1'h0;
        sclr <= 1'h0;
        @(posedge clock_i);
        #1;
        chk("flags_cleared", {status.watchdog_overflow_flag, status.soft_reset_flag}, 2'h0);
    endtask

    // Soft reset sequence with a chosen pin disable and speed mode.
    task automatic t_soft(input logic rod, input logic ds);
        @(posedge clock_i);
        cfg.reset_out_disable <= rod;
        cfg.double_speed_mode <= ds;
        send(8'h5A, 8'hA5, 1'h1);
        pulse_chk(ds ? `HWD_PULSE_DOUBLE : `HWD_PULSE_NORMAL, !rod);
        chk("running_after_soft", status.watchdog_running_flag, 1'h0);
        clr(1'h0, 1'h1);
    endtask

    // With the clock enable low a whole soft reset sequence must be ignored.
    task automatic t_freeze();
        @(posedge clock_i);
        ce <= 1'h0;
        send(8'h5A, 8'hA5, 1'h1);
        ce <= 1'h1;
        @(posedge clock_i);
        #1;
        chk("frozen_pulse", pulse, 1'h0);
        chk("frozen_soft", status.soft_reset_flag, 1'h0);
    endtask

    // A wrong sequence must reset at once and raise both flags.
    task automatic t_err(input logic [7:0] a, input logic [7:0] b, input bit two);
        send(a, b, two);
        pulse_chk(`HWD_PULSE_NORMAL, 1'h1);
        clr(1'h1, 1'h1);
    endtask

    // Time-out run: mode 0 power-down pause, 1 idle with halt, 2 idle without halt.
    task automatic t_to(input logic [6:0] presc, input int pause, input int mode, input int feed_at);
        int n = 0;
        int e;
        e = 32'h4000 * (presc + 1) + ((mode != 2) ? pause : 0);
        @(posedge clock_i);
        cfg.timer_prescale_select <= presc;
        cfg.period_select <= 3'h0;
        cfg.idle_halt_select <= (mode == 1);
        send(8'h1E, 8'hE1, 1'h1);
        @(posedge clock_i);
        #1;
        chk("running", status.watchdog_running_flag, 1'h1);
        if (feed_at > 0) begin
            repeat (feed_at) @(posedge clock_i);
            send(8'h1E, 8'hE1, 1'h1);
            @(posedge clock_i);
        end
        idle <= (mode != 0);
        pdn <= (mode == 0);
        repeat (pause) @(posedge clock_i);
        idle <= 1'h0;
        pdn <= 1'h0;
        n = pause;
        #1;
        while (pulse !== 1'h1 && n < e + 8) begin
            n++;
            @(posedge clock_i);
            #1;
        end
        chk("timeout_window", (n >= e - 8) && (n < e + 8), 1'h1);
        chk("running_at_timeout", status.watchdog_running_flag, 1'h0);
        while (pulse === 1'h1) @(posedge clock_i);
        #1;
        clr(1'h1, 1'h0);
    endtask

    // Hang guard, well above the roughly 75K cycles that the scenarios need.
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // Main sequence.
    initial begin
        rst_i = 1'h1;
        seq_wr = 1'h0;
        ce = 1'h1;
        seq_data = 8'h00;
        idle = 1'h0;
        pdn = 1'h0;
        oclr = 1'h0;
        sclr = 1'h0;
        cfg = '{`HWD_PRESCALE_DEFAULT, 3'h0, 1'h0, 1'h0, 1'h0};
        repeat (20) @(posedge clock_i);
        rst_i <= 1'h0;
        @(posedge clock_i);
        #1;
        chk("status_after_reset", status, 3'h0);
        chk("pulse_after_reset", pulse, 1'h0);
        t_freeze();
        t_soft(1'h0, 1'h0);
        t_soft(1'h1, 1'h1);
        send(8'h1E, 8'hE1, 1'h1);
        t_soft(1'h0, 1'h0);
        t_err(8'h33, 8'h00, 1'h0);
        t_err(8'h1E, 8'h33, 1'h1);
        t_err(8'h5A, 8'hE1, 1'h1);
        t_to(7'h01, 300, 0, 0);
        t_to(7'h00, 300, 1, 8000);
        t_to(7'h00, 300, 2, 0);
        tally_and_finish();
    end
endmodule // hwd_watchdog_bench
